// File: src/pdc_cfg.svh
// Summary of operation
// - Halt instruction enters low-power state.
// - Halt-entered power-down never acknowledges hold, but a hold request masks its interrupt wake.
// - Halt power-down ends on reset or interrupt.
// - Hold request during non-halt enters power-down.
// - Interrupts ignored while in hold status.
// - Hold power-down ends on reset or release.
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH

// ----------------------------------------------------------------
// Interrupt input positions within the combined request vector
// ----------------------------------------------------------------
`define IRQ_TRAP_BIT 0
`define IRQ_HIGH_BIT 1
`define IRQ_MID_BIT  2
`define IRQ_LOW_BIT  3
`define IRQ_GEN_BIT  4
`define IRQ_COUNT    5

`endif

// File: src/pdc_pkg.sv
package pdc_pkg;
   typedef enum logic [1:0] {
      PD_RUN,
      PD_HALT,
      PD_HOLD
   } pd_state_t;
endpackage : pdc_pkg

// File: src/irq_accept.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_cfg.svh"

// ----------------------------------------------------------------
// Interrupt acceptance
// ----------------------------------------------------------------
module irq_accept #(
   parameter int N = `IRQ_COUNT
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   // Requests
   input  wire logic [N-1:0] irq_in,
   input  wire logic         hold_active,
   // Result
   output logic              irq_wake
);
   logic irq_wake_nxt;

   // A hold masks every interrupt, non-maskable trap included.
   always_comb begin
      irq_wake_nxt = (|irq_in) & ~hold_active;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_wake <= 1'b0;
      end else begin
         irq_wake <= irq_wake_nxt;
      end
   end
endmodule : irq_accept

`default_nettype wire

// File: src/cpu_power_down_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_cfg.svh"

module cpu_power_down_control (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // Core status
   input  wire logic              halt_exec,
   // External master
   input  wire logic              hold_req,
   output var  logic              hold_ack,
   // Interrupt inputs
   input  wire logic              trap_irq,
   input  wire logic              restart_irq_high,
   input  wire logic              restart_irq_mid,
   input  wire logic              restart_irq_low,
   input  wire logic              general_irq_request,
   // Power control
   output var  logic              power_down,
   output var  logic              core_stall,
   output var  logic              halt_mode,
   output var  logic              resume_pulse,
   output var  logic              wake_irq
);
   import pdc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pd_state_t            state_r, state_nxt;
   logic                 hold_ack_nxt, pd_nxt, resume_nxt, wake_nxt;
   logic                 halt_nxt;
   logic [`IRQ_COUNT-1:0] irq_vec;
   logic                 irq_wake;

   // ----------------------------------------------------------------
   // Interrupt gathering
   // ----------------------------------------------------------------
   // All five sources wake the core alike; there is no priority here because
   // the vectoring happens in the core once it runs again.
   assign irq_vec[`IRQ_TRAP_BIT] = trap_irq;
   assign irq_vec[`IRQ_HIGH_BIT] = restart_irq_high;
   assign irq_vec[`IRQ_MID_BIT]  = restart_irq_mid;
   assign irq_vec[`IRQ_LOW_BIT]  = restart_irq_low;
   assign irq_vec[`IRQ_GEN_BIT]  = general_irq_request;

   // Interrupts are registered once before the state flop, so a wake lands two cycles after the pin.
   irq_accept #(.N(`IRQ_COUNT)) u_irq (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .irq_in      (irq_vec),
      .hold_active (hold_req),
      .irq_wake    (irq_wake)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt  = state_r;
      resume_nxt = 1'b0;
      wake_nxt   = 1'b0;
      case (state_r)
         PD_RUN: begin
            // Halt is looked at first, so a halt that meets a hold is a halt.
            if (halt_exec) begin
               state_nxt = PD_HALT;
            end else if (hold_req) begin
               state_nxt = PD_HOLD;
            end
         end
         PD_HALT: begin
            // Hold changes are not looked at here at all.
            if (irq_wake) begin
               state_nxt = PD_RUN;
               wake_nxt  = 1'b1;
            end
         end
         PD_HOLD: begin
            // Core state is frozen, not cleared, so the program continues.
            if (!hold_req) begin
               state_nxt  = PD_RUN;
               resume_nxt = 1'b1;
            end
         end
         default: state_nxt = PD_RUN;
      endcase
      pd_nxt       = (state_nxt != PD_RUN);
      hold_ack_nxt = (state_nxt == PD_HOLD);
      halt_nxt     = (state_nxt == PD_HALT);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Every output is a flop fed from the next-state decode, so the status
   // lines never glitch while the request pins settle.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r      <= PD_RUN;
         power_down   <= 1'b0;
         core_stall   <= 1'b0;
         halt_mode    <= 1'b0;
         hold_ack     <= 1'b0;
         resume_pulse <= 1'b0;
         wake_irq     <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         power_down   <= pd_nxt;
         core_stall   <= pd_nxt;
         halt_mode    <= halt_nxt;
         hold_ack     <= hold_ack_nxt;
         resume_pulse <= resume_nxt;
         wake_irq     <= wake_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   halt_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_RUN && halt_exec) |=> (power_down && halt_mode))
      else $error("Halt did not enter power-down.");

   halt_holdfree_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_HALT && !irq_wake) |=> halt_mode)
      else $error("Halt power-down left without interrupt.");

   halt_irq_exit_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_HALT && irq_wake) |=> (!power_down && wake_irq))
      else $error("Interrupt did not release halt power-down.");

   hold_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_RUN && !halt_exec && hold_req) |=> (power_down && hold_ack))
      else $error("Hold did not enter power-down.");

   hold_no_irq_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_HOLD && hold_req) |=> (hold_ack && !wake_irq))
      else $error("Hold power-down released while hold still asserted.");

   hold_release_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_HOLD && !hold_req) |=> (!power_down && !hold_ack))
      else $error("Hold removal did not release power-down.");

   resume_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
      resume_pulse |-> ($past(hold_ack) && !core_stall))
      else $error("Resume without preceding hold power-down.");

   stall_match_a: assert property (@(posedge mclk) disable iff (sys_rst)
      core_stall == power_down)
      else $error("Core stall disagrees with power-down.");

   // ----------------------------------------------------------------
   // Entry checks
   // ----------------------------------------------------------------
   // A halt and a hold taken on the same edge must settle on the halt mode.
   halt_priority_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_RUN && halt_exec && hold_req) |=> (halt_mode && !hold_ack))
      else $error("Hold took priority over a halt.");

   pd_rise_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(power_down) |-> ($past(halt_exec) || $past(hold_req)))
      else $error("Power-down began without halt or hold.");

   run_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_RUN && !halt_exec && !hold_req) |=> !power_down)
      else $error("Power-down began while idle.");

   // ----------------------------------------------------------------
   // Exit checks
   // ----------------------------------------------------------------
   // The mask sits before the interrupt register, so a request seen while
   // hold was up can never wake a halted core one cycle later.
   halt_irq_mask_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_HALT && $past(hold_req)) |=> halt_mode)
      else $error("Interrupt released halt during hold.");

   halt_no_ack_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_r == PD_HALT && hold_req) |=> !hold_ack)
      else $error("Hold acknowledged during halt power-down.");

   wake_source_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wake_irq |-> ($past(halt_mode) && !power_down))
      else $error("Wake pulse outside a halt exit.");

   wake_needs_irq_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wake_irq |-> $past(irq_wake))
      else $error("Wake pulse without an accepted interrupt.");

   pd_exit_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(power_down) |-> (wake_irq || resume_pulse))
      else $error("Power-down ended without interrupt or hold removal.");

   // ----------------------------------------------------------------
   // Mode output checks
   // ----------------------------------------------------------------
   // The two modes exclude each other and both pulses last one cycle.
   hold_ack_pd_a: assert property (@(posedge mclk) disable iff (sys_rst)
      hold_ack |-> (power_down && !halt_mode))
      else $error("Hold acknowledge outside hold power-down.");

   halt_mode_pd_a: assert property (@(posedge mclk) disable iff (sys_rst)
      halt_mode |-> (power_down && !hold_ack))
      else $error("Halt mode outside halt power-down.");

   wake_once_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wake_irq |=> !wake_irq)
      else $error("Wake pulse longer than one cycle.");

   resume_once_a: assert property (@(posedge mclk) disable iff (sys_rst)
      resume_pulse |=> !resume_pulse)
      else $error("Resume pulse longer than one cycle.");
endmodule : cpu_power_down_control

`default_nettype wire

// File: sim/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the core, the bus master and the interrupt sources; the
// scenarios set its commands just after a rising mclk, never on it.
module bus_master_model (
   // Commands from the scenarios
   input  wire logic       halt_cmd,
   input  wire logic       hold_cmd,
   input  wire logic [4:0] irq_cmd,
   // Lines seen by the block
   output var  logic       halt_exec,
   output var  logic       hold_req,
   output var  logic [4:0] irq
);
   // The master alone decides when hold drops; the block never times it out.
   always_comb begin
      halt_exec = halt_cmd;
      hold_req  = hold_cmd;
      irq       = irq_cmd;
   end
endmodule : bus_master_model
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       mclk, sys_rst, halt_cmd, hold_cmd, halt_exec, hold_req, hold_ack;
   logic       power_down, core_stall, halt_mode, resume_pulse, wake_irq;
   logic [4:0] irq_cmd, irq;
   int         n_mismatch, checks_done;
   bus_master_model src_u (.halt_cmd(halt_cmd), .hold_cmd(hold_cmd), .irq_cmd(irq_cmd),
      .halt_exec(halt_exec), .hold_req(hold_req), .irq(irq));
   cpu_power_down_control dut_u (.mclk(mclk), .sys_rst(sys_rst), .halt_exec(halt_exec),
      .hold_req(hold_req), .hold_ack(hold_ack), .trap_irq(irq[0]), .restart_irq_high(irq[1]),
      .restart_irq_mid(irq[2]), .restart_irq_low(irq[3]), .general_irq_request(irq[4]),
      .power_down(power_down), .core_stall(core_stall), .halt_mode(halt_mode),
      .resume_pulse(resume_pulse), .wake_irq(wake_irq));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   // One status byte lets each check compare all six outputs in a single compare.
   function automatic logic [7:0] st();
      return {2'b00, power_down, core_stall, halt_mode, hold_ack, resume_pulse, wake_irq};
   endfunction : st
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : tick
   task automatic halt_wake(input int b);
      halt_cmd = 1'b1;
      tick(1);
      halt_cmd = 1'b0;
      check(st(), 8'h38);
      hold_cmd = 1'b1;
      tick(1);
      irq_cmd = 5'h01 << b;
      tick(1);
      check(st(), 8'h38);
      irq_cmd = 5'h00;
      hold_cmd = 1'b0;
      tick(2);
      check(st(), 8'h38);
      irq_cmd = 5'h01 << b;
      tick(1);
      check(st(), 8'h38);
      tick(1);
      check(st(), 8'h01);
      irq_cmd = 5'h00;
      tick(1);
      check(st(), 8'h00);
   endtask : halt_wake
   task automatic halt_over_hold();
      halt_cmd = 1'b1;
      hold_cmd = 1'b1;
      tick(1);
      halt_cmd = 1'b0;
      check(st(), 8'h38);
      tick(1);
      check(st(), 8'h38);
      hold_cmd = 1'b0;
      irq_cmd = 5'h10;
      tick(2);
      check(st(), 8'h01);
      irq_cmd = 5'h00;
      tick(1);
      check(st(), 8'h00);
   endtask : halt_over_hold
   task automatic hold_cycle();
      hold_cmd = 1'b1;
      tick(1);
      check(st(), 8'h34);
      irq_cmd = 5'h1f;
      tick(3);
      check(st(), 8'h34);
      irq_cmd = 5'h00;
      tick(2);
      hold_cmd = 1'b0;
      tick(1);
      check(st(), 8'h02);
      tick(1);
      check(st(), 8'h00);
   endtask : hold_cycle
   task automatic reset_exit();
      hold_cmd = 1'b1;
      tick(1);
      check(st(), 8'h34);
      sys_rst = 1'b1;
      tick(1);
      check(st(), 8'h00);
      sys_rst = 1'b0;
      check(st(), 8'h00);
      tick(1);
      check(st(), 8'h34);
      hold_cmd = 1'b0;
      tick(1);
      check(st(), 8'h02);
      tick(1);
      check(st(), 8'h00);
   endtask : reset_exit
   task automatic print_verdict();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      n_mismatch = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      halt_cmd = 1'b0;
      hold_cmd = 1'b0;
      irq_cmd = 5'h00;
      repeat (12) @(posedge mclk);
      #2 sys_rst = 1'b0;
      tick(1);
      for (int b = 0; b < 5; b++) begin
         halt_wake(b);
      end
      halt_over_hold();
      hold_cycle();
      reset_exit();
      print_verdict();
   end
   // The scenarios need about 71 cycles; the 440-cycle limit is six times that.
   initial begin
      #22000;
      n_mismatch++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
